// ---- include/sfr_consts.vh ----
// constants of the serial flash read sequencer: opcodes, header lengths, page geometry
// assumes nothing; definitions only
`ifndef SFR_CONSTS_VH
`define SFR_CONSTS_VH

`define SFR_OP_CONT_FAST   8'h0B
`define SFR_OP_CONT_SLOW   8'h03
`define SFR_OP_CONT_LOWPWR 8'h01
`define SFR_OP_PAGE_READ   8'hD2
`define SFR_OP_BUF1_FAST   8'hD4
`define SFR_OP_BUF1_SLOW   8'hD1
`define SFR_OP_BUF2_FAST   8'hD6
`define SFR_OP_BUF2_SLOW   8'hD3

`define SFR_KIND_NONE      2'h0
`define SFR_KIND_CONT      2'h1
`define SFR_KIND_PAGE      2'h2
`define SFR_KIND_BUF       2'h3

`define SFR_OPC_BITS       6'h08
`define SFR_ADDR_BITS      6'h18
`define SFR_DUMMY_FAST     3'h1
`define SFR_DUMMY_PAGE     3'h4
`define SFR_DUMMY_NONE     3'h0

`define SFR_LAST_BYTE_528  10'h20F
`define SFR_LAST_BYTE_512  10'h1FF

`define SFR_ST_IDLE        3'h0
`define SFR_ST_OPC         3'h1
`define SFR_ST_ADDR        3'h2
`define SFR_ST_DUMMY       3'h3
`define SFR_ST_DATA        3'h4
`define SFR_ST_IGNORE      3'h5

// reset levels of the synchronised pins: bit0 select (high), bit1 clock, bit2 data
`define SFR_PIN_IDLE       3'h1

`endif

// ---- hw/sfr_read_seq.v ----
// serial flash read-command sequencer: decodes the read opcodes from the serial link
// and streams array or buffer bytes out on the serial output.
// assumes cs/sck/si arrive asynchronously from pins, sck well below a quarter of i_sys_clk,
// and that the array and buffer storage answer one i_sys_clk cycle after a read pulse.
//
// Notes on behaviour
// R1: cs low starts; 8-bit opcode then address
// R2: every field shifted most significant bit first
// R3: 0Bh takes three address, one dummy byte
// R4: 528 mode: 13 page bits, 10 byte bits
// R5: 512 mode: 13 page bits, 9 byte bits
// R6: 03h has no dummy byte
// R7: 01h behaves exactly like 03h
// R8: continuous read crosses pages without delay
// R9: end of array wraps to page zero
// R10: host keeps cs low whole command
// R11: cs high ends read, output released
// R12: array reads never touch the buffers
// R13: D2h takes address plus four dummy bytes
// R14: page read wraps within same page
// R15: D4h/D1h buffer one, D6h/D3h buffer two
// R16: 528 buffer: 14 dummy, 10 offset bits
// R17: 512 buffer: 15 dummy, 9 offset bits
// R18: only D4h and D6h take dummy byte
// R19: buffer read wraps to buffer start
// R20: host matches opcode to clock class
// R21: sample on sck rise, drive after fall
`timescale 1ns/1ps
`include "sfr_consts.vh"

module sfr_read_seq (
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  input  wire        i_page_512,
  input  wire        i_cs_n,
  input  wire        i_sck,
  input  wire        i_si,
  output reg         o_so,
  output reg         o_so_oe,
  output reg         o_arr_rd,
  output reg  [12:0] o_page_index_bits,
  output reg  [9:0]  o_byte_offset_bits,
  input  wire [7:0]  i_arr_data,
  output reg         o_buf_rd,
  output reg         o_buf_sel,
  input  wire [7:0]  i_buf_data
);

  // opcode class; used by the header decode and by the kind_reg load
  function [1:0] op_kind;
    input [7:0] op;
    begin
      case (op)
        `SFR_OP_CONT_FAST, `SFR_OP_CONT_SLOW, `SFR_OP_CONT_LOWPWR: op_kind = `SFR_KIND_CONT;
        `SFR_OP_PAGE_READ:                                         op_kind = `SFR_KIND_PAGE;
        `SFR_OP_BUF1_FAST, `SFR_OP_BUF1_SLOW,
        `SFR_OP_BUF2_FAST, `SFR_OP_BUF2_SLOW:                      op_kind = `SFR_KIND_BUF;
        default:                                                   op_kind = `SFR_KIND_NONE;
      endcase
    end
  endfunction

  function [2:0] op_dummy;
    input [7:0] op;
    begin
      case (op)
        `SFR_OP_CONT_FAST, `SFR_OP_BUF1_FAST, `SFR_OP_BUF2_FAST: op_dummy = `SFR_DUMMY_FAST; // see R3 see R18
        `SFR_OP_PAGE_READ:                                     op_dummy = `SFR_DUMMY_PAGE; // see R13
        default:                                               op_dummy = `SFR_DUMMY_NONE; // see R6 see R7
      endcase
    end
  endfunction

  // states and the reset levels of the three pins
  localparam [2:0] ST_IDLE   = `SFR_ST_IDLE;
  localparam [2:0] ST_OPC    = `SFR_ST_OPC;
  localparam [2:0] ST_ADDR   = `SFR_ST_ADDR;
  localparam [2:0] ST_DUMMY  = `SFR_ST_DUMMY;
  localparam [2:0] ST_DATA   = `SFR_ST_DATA;
  localparam [2:0] ST_IGNORE = `SFR_ST_IGNORE;
  localparam [2:0] PIN_IDLE  = `SFR_PIN_IDLE;

  // start offset inside a page or a buffer; upper address bits are don't-care
  function [9:0] start_offset;
    input [23:0] a;
    input        is_512;
    begin
      start_offset = is_512 ? {1'b0, a[8:0]} : a[9:0]; // see R4 see R5 see R16 see R17
    end
  endfunction

  function [12:0] start_page;
    input [23:0] a;
    input        is_512;
    begin
      start_page = is_512 ? a[21:9] : a[22:10]; // see R4 see R5
    end
  endfunction

  // byte after off, folding back to zero past the last byte
  function [9:0] next_offset;
    input [9:0] off;
    input [9:0] last;
    begin
      next_offset = (off == last) ? 10'h000 : off + 10'h001;
    end
  endfunction

  // buffer two is chosen by its own pair of opcodes
  function buffer_of;
    input [7:0] op;
    begin
      case (op)
        `SFR_OP_BUF2_FAST, `SFR_OP_BUF2_SLOW: buffer_of = 1'b1; // see R15
        default:                              buffer_of = 1'b0; // see R15
      endcase
    end
  endfunction

  // two-flop synchronisers, one per pin; stage one feeds only stage two
  wire [2:0] pin_async = {i_si, i_sck, i_cs_n};
  wire [2:0] pin_sync;
  genvar     g;

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      reg meta_reg;
      reg sync_reg;
      always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          meta_reg <= PIN_IDLE[g];
          sync_reg <= PIN_IDLE[g];
        end else begin
          meta_reg <= pin_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign pin_sync[g] = sync_reg;
    end
  endgenerate

  wire cs_n_sync = pin_sync[0];
  wire sck_sync  = pin_sync[1];
  wire si_sync   = pin_sync[2];

  reg  sck_prev_reg;

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_sync;
    end
  end

  // si passes as many flops as sck, so its bit is settled when the rise is seen
  wire sck_rise = sck_sync & ~sck_prev_reg; // see R21
  wire sck_fall = ~sck_sync & sck_prev_reg; // see R21

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [5:0]  cnt_reg;
  reg  [5:0]  cnt_next;
  reg  [7:0]  op_reg;
  reg  [23:0] addr_reg;
  reg  [1:0]  kind_reg;
  reg  [2:0]  bit_reg;
  reg  [7:0]  byte_reg;
  reg         fetch_wait_reg;
  reg         start_rd;
  reg  [23:0] start_addr;

  wire [23:0] addr_full  = {addr_reg[22:0], si_sync}; // see R2
  wire [7:0]  op_full    = {op_reg[6:0], si_sync};    // see R2
  wire [5:0]  dummy_bits = {op_dummy(op_reg), 3'h0};
  wire [9:0]  last_byte  = i_page_512 ? `SFR_LAST_BYTE_512 : `SFR_LAST_BYTE_528;
  wire        opc_rise   = !cs_n_sync && sck_rise && (state_reg == ST_OPC);
  wire        addr_rise  = !cs_n_sync && sck_rise && (state_reg == ST_ADDR);
  wire        data_fall  = !cs_n_sync && sck_fall && (state_reg == ST_DATA);
  wire        byte_end   = data_fall && (bit_reg == 3'h7);

  // header sequencing; a deselect wins over any clock edge in the same cycle
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    start_rd   = 1'b0;
    start_addr = addr_reg;
    if (cs_n_sync) begin
      state_next = ST_IDLE; // see R11
      cnt_next   = 6'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_OPC; // see R1
          cnt_next   = 6'h00;
        end
        ST_OPC: begin
          if (sck_rise) begin
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == `SFR_OPC_BITS - 6'h01) begin // see R1
              cnt_next   = 6'h00;
              // unknown or non-read opcodes are left alone until deselect
              state_next = (op_kind(op_full) == `SFR_KIND_NONE) ? ST_IGNORE : ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == `SFR_ADDR_BITS - 6'h01) begin
              cnt_next = 6'h00;
              if (op_dummy(op_reg) == `SFR_DUMMY_NONE) begin
                state_next = ST_DATA; // see R6 see R7 see R18
                start_rd   = 1'b1;
                start_addr = addr_full;
              end else begin
                state_next = ST_DUMMY;
              end
            end
          end
        end
        ST_DUMMY: begin
          if (sck_rise) begin
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == dummy_bits - 6'h01) begin // see R3 see R13 see R18
              cnt_next   = 6'h00;
              state_next = ST_DATA;
              start_rd   = 1'b1;
            end
          end
        end
        ST_DATA: begin
          state_next = ST_DATA;
        end
        ST_IGNORE: begin
          state_next = ST_IGNORE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // opcode and address shift registers
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 6'h00;
      op_reg    <= 8'h00;
      addr_reg  <= 24'h000000;
      kind_reg  <= `SFR_KIND_NONE;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (opc_rise) begin
        op_reg <= op_full;
        if (cnt_reg == `SFR_OPC_BITS - 6'h01) begin
          kind_reg <= op_kind(op_full);
        end
      end
      if (addr_rise) begin
        addr_reg <= addr_full;
      end
    end
  end

  // serial output; the level is kept on deselect, only the enable drops
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bit_reg <= 3'h0;
      o_so    <= 1'b0;
      o_so_oe <= 1'b0;
    end else if (cs_n_sync) begin
      o_so_oe <= 1'b0; // see R11
    end else if (start_rd) begin
      bit_reg <= 3'h0;
    end else if (data_fall) begin
      o_so_oe <= 1'b1;
      o_so    <= byte_reg[3'h7 - bit_reg]; // see R2 see R21
      bit_reg <= bit_reg + 3'h1;
    end
  end

  // storage answers one cycle after the read pulse; capture it then
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fetch_wait_reg <= 1'b0;
      byte_reg       <= 8'h00;
    end else begin
      fetch_wait_reg <= start_rd || byte_end;
      if (fetch_wait_reg) begin
        byte_reg <= (kind_reg == `SFR_KIND_BUF) ? i_buf_data : i_arr_data;
      end
    end
  end

  // read port: first fetch at header end, then one per byte shifted out
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_arr_rd           <= 1'b0;
      o_buf_rd           <= 1'b0;
      o_buf_sel          <= 1'b0;
      o_page_index_bits  <= 13'h0000;
      o_byte_offset_bits <= 10'h000;
    end else begin
      o_arr_rd <= 1'b0;
      o_buf_rd <= 1'b0;
      if (start_rd) begin
        o_byte_offset_bits <= start_offset(start_addr, i_page_512); // see R4 see R5 see R16 see R17
        if (kind_reg == `SFR_KIND_BUF) begin
          o_page_index_bits <= 13'h0000;
          o_buf_rd          <= 1'b1;
          o_buf_sel         <= buffer_of(op_reg); // see R15
        end else begin
          o_page_index_bits <= start_page(start_addr, i_page_512); // see R4 see R5
          o_arr_rd          <= 1'b1;
        end
      end else if (byte_end) begin
        // next byte fetched a full clock period before its first bit is due
        o_byte_offset_bits <= next_offset(o_byte_offset_bits, last_byte); // see R8 see R14 see R19
        if (kind_reg == `SFR_KIND_BUF) begin
          o_buf_rd <= 1'b1;
        end else begin
          o_arr_rd <= 1'b1; // array path only, buffers never written; see R12
          if (kind_reg == `SFR_KIND_CONT && o_byte_offset_bits == last_byte) begin
            o_page_index_bits <= o_page_index_bits + 13'h0001; // 8191 rolls to 0; see R8 see R9
          end
        end
      end
    end
  end

endmodule // sfr_read_seq

// ---- test/sfr_read_seq_properties.sv ----
// checker of the read sequencer: read ports and serial output timing
// assumes it is bound to the sequencer and sees only its ports
`timescale 1ns/1ps
module sfr_read_seq_properties (
  input wire        i_sys_clk,
  input wire        i_rst_n,
  input wire        i_page_512,
  input wire        i_cs_n,
  input wire        i_sck,
  input wire        o_so,
  input wire        o_so_oe,
  input wire        o_arr_rd,
  input wire [12:0] o_page_index_bits,
  input wire [9:0]  o_byte_offset_bits,
  input wire        o_buf_rd,
  input wire        o_buf_sel
);
  reg        seq_reg;
  reg        arr_reg;
  reg [12:0] pg_reg;
  reg [9:0]  of_reg;
  wire       rd  = o_arr_rd | o_buf_rd;
  wire [9:0] lst = i_page_512 ? 10'h1FF : 10'h20F;
  wire [9:0] nof = (of_reg == lst) ? 10'h000 : of_reg + 10'h001;
  // previous read of the same selection, forgotten when select rises
  always @(posedge i_sys_clk) begin
    seq_reg <= i_rst_n && !i_cs_n && (rd || seq_reg);
    if (rd) begin
      arr_reg <= o_arr_rd;
      pg_reg  <= o_page_index_bits;
      of_reg  <= o_byte_offset_bits;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_idle_quiet: assert property (i_cs_n [*5] |-> !o_so_oe && !rd)
    else $error("active while deselected");
  a_so_steady: assert property (i_sck [*5] |-> $stable(o_so))
    else $error("output moved while clock high");
  a_rd_gap: assert property (rd |=> !rd [*8])
    else $error("reads closer than a byte");
  a_no_mix: assert property (o_buf_rd |-> !o_arr_rd && !(seq_reg && arr_reg))
    else $error("buffer read during array read");
  a_arr_step: assert property (o_arr_rd && seq_reg |-> o_byte_offset_bits == nof &&
    (o_page_index_bits == pg_reg || nof == 10'h000 && o_page_index_bits == pg_reg + 13'h0001))
    else $error("array address step wrong");
  a_buf_step: assert property (o_buf_rd && seq_reg |-> o_byte_offset_bits == nof && $stable(o_buf_sel))
    else $error("buffer address step wrong");
  a_off_range: assert property (rd |-> o_byte_offset_bits <= lst)
    else $error("offset beyond page");
  a_buf_page: assert property (o_buf_rd |-> o_page_index_bits == 13'h0000)
    else $error("page set on buffer read");
endmodule // sfr_read_seq_properties

bind sfr_read_seq sfr_read_seq_properties u_props (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_page_512(i_page_512), .i_cs_n(i_cs_n), .i_sck(i_sck),
  .o_so(o_so), .o_so_oe(o_so_oe), .o_arr_rd(o_arr_rd), .o_page_index_bits(o_page_index_bits),
  .o_byte_offset_bits(o_byte_offset_bits), .o_buf_rd(o_buf_rd), .o_buf_sel(o_buf_sel));

// ---- test/sfr_host_model.sv ----
// host on the serial link: drives select, clock and input, gathers output bytes
// assumes the device moves its output after clock falls; clock idles low or high as asked
`timescale 1ns/1ps
module sfr_host_model (
  input  wire       i_sys_clk,
  input  wire       i_so,
  input  wire       i_idle_hi,
  output reg        o_cs_n,
  output reg        o_sck,
  output reg        o_si,
  output reg  [7:0] o_byte,
  output reg        o_byte_vld
);
  initial {o_cs_n, o_sck, o_si, o_byte, o_byte_vld} = 12'h800;
  task half;
    repeat (8) @(negedge i_sys_clk);
  endtask
  task bit_io(input b, output r);
    begin
      o_si = b;
      o_sck = 1'b0; // with an idle-high clock the falling edge starts the bit
      half;
      o_sck = 1'b1;
      r = i_so;
      half;
      o_sck = i_idle_hi;
    end
  endtask
  // one clock rate for all opcodes: it sits inside the slowest class
  task cmd(input [7:0] op, input [23:0] a, input [2:0] nd, input [3:0] nr);
    reg [63:0] h;
    reg        r;
    integer    i;
    integer    j;
    begin
      h = {op, a, 32'hA5C396F0};
      o_sck = i_idle_hi;
      half;
      o_cs_n = 1'b0;
      half;
      for (i = 0; i < 32 + 8 * nd; i = i + 1)
        bit_io(h[63 - i], r);
      for (j = 0; j < nr; j = j + 1) begin
        for (i = 7; i >= 0; i = i - 1) begin
          bit_io(~o_si, r);
          o_byte[i] = r;
        end
        o_byte_vld = 1'b1;
        @(negedge i_sys_clk);
        o_byte_vld = 1'b0;
      end
      o_cs_n = 1'b1;
      repeat (16) @(negedge i_sys_clk);
    end
  endtask
endmodule // sfr_host_model

// ---- test/sfr_read_seq_test.sv ----
// bench of the read sequencer: host model on the link, storage models on the read ports
// assumes host model and checker are compiled first
`timescale 1ns/1ps
`include "sfr_consts.vh"
module sfr_read_seq_test;
  reg         sys_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         page_512 = 1'b0;
  reg         sck_idle_hi = 1'b0;
  reg  [7:0]  arr_data = 8'h00;
  reg  [7:0]  buf_data = 8'h00;
  wire        cs_n, sck, si, so, so_oe, arr_rd, buf_rd, buf_sel, byte_vld;
  wire [12:0] page_idx;
  wire [9:0]  byte_off;
  wire [7:0]  rx_byte;
  wire        so_line = so_oe ? so : ~so;
  reg  [7:0]  ops [0:7] = '{`SFR_OP_CONT_FAST, `SFR_OP_CONT_SLOW, `SFR_OP_CONT_LOWPWR, `SFR_OP_PAGE_READ,
                          `SFR_OP_BUF1_FAST, `SFR_OP_BUF1_SLOW, `SFR_OP_BUF2_FAST, `SFR_OP_BUF2_SLOW};
  reg  [2:0]  dum [0:7] = '{3'h1, 3'h0, 3'h0, 3'h4, 3'h1, 3'h0, 3'h1, 3'h0};
  reg  [7:0]  exp_q [$];
  reg  [12:0] pg;
  reg  [9:0]  of;
  reg  [9:0]  last;
  reg  [31:0] r;
  integer     n_errors = 0, cmp_count = 0, cyc = 0, k, m, b;

  always #5 sys_clk = ~sys_clk;

  function [7:0] f_arr(input [12:0] p, input [9:0] o);
    f_arr = p[7:0] ^ o[7:0] ^ {o[9:8], p[12:7]};
  endfunction
  function [7:0] f_buf(input s, input [9:0] o);
    f_buf = ~o[7:0] ^ {s, 5'h00, o[9:8]};
  endfunction
  // data is good for one cycle only, then garbled so stale bytes cannot pass
  always @(negedge sys_clk) begin
    arr_data <= arr_rd ? f_arr(page_idx, byte_off) : ~arr_data;
    buf_data <= buf_rd ? f_buf(buf_sel, byte_off) : ~buf_data;
  end

  sfr_read_seq uut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_page_512(page_512), .i_cs_n(cs_n),
    .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe), .o_arr_rd(arr_rd), .o_page_index_bits(page_idx),
    .o_byte_offset_bits(byte_off), .i_arr_data(arr_data), .o_buf_rd(buf_rd), .o_buf_sel(buf_sel),
    .i_buf_data(buf_data));
  sfr_host_model u_host (.i_sys_clk(sys_clk), .i_so(so_line), .i_idle_hi(sck_idle_hi), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si),
    .o_byte(rx_byte), .o_byte_vld(byte_vld));

  task chk_byte(input [7:0] e, input [7:0] s);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("MISMATCH so_byte expected %h seen %h", e, s);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  always @(posedge byte_vld) chk_byte(exp_q.pop_front(), rx_byte);
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 70000) begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end

  initial begin
    r = $urandom(32'hBD664085);
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    for (m = 0; m < 4; m = m + 1) begin
      page_512 = m[0];
      sck_idle_hi = m[1];
      last = m[0] ? 10'h1FF : 10'h20F;
      for (k = 0; k < 8; k = k + 1) begin
        r = $urandom;
        pg = (k < 3) ? 13'h1FFF : r[12:0];
        of = last - 10'h001;
        r[23:0] = m[0] ? {r[23:22], pg, of[8:0]} : {r[23], pg, of};
        for (b = 0; b < 3; b = b + 1) begin
          exp_q.push_back(k > 3 ? f_buf(k > 5, of) : f_arr(pg, of));
          of = (of == last) ? 10'h000 : of + 10'h001;
          pg = (of == 10'h000 && k < 3) ? pg + 13'h0001 : pg;
        end
        u_host.cmd(ops[k], r[23:0], dum[k], 4'h3);
      end
    end
    if (exp_q.size() != 0)
      n_errors = n_errors + 1;
    complete_run;
  end
endmodule // sfr_read_seq_test
